// [hdl/dialer_pkg.sv]
// constants shared by the pulse dialer and its digit memory
package dialer_pkg;
   // ==========================================================
   // clock and time base
   localparam int unsigned CLK_MHZ        = 10;
   localparam int unsigned TICK_US        = 1000;
   localparam int unsigned TICK_CYCLES    = TICK_US * CLK_MHZ;
   // ==========================================================
   // times in ms ticks
   localparam int unsigned DEBOUNCE_MS    = 20;
   localparam int unsigned PREDIAL_MS     = 300;
   localparam int unsigned INTERDIGIT_MS  = 800;
   localparam int unsigned PERIOD10_MS    = 100;
   localparam int unsigned PERIOD20_MS    = 50;
   localparam int unsigned BRK10_A_MS     = 60;
   localparam int unsigned BRK10_B_MS     = 67;
   localparam int unsigned BRK20_A_MS     = 30;
   localparam int unsigned BRK20_B_MS     = 33;
   localparam int unsigned ONHOOK_MIN_MS  = 500;
   localparam int unsigned ONHOOK_CYCLES  = ONHOOK_MIN_MS * TICK_CYCLES;
   // ==========================================================
   // memory and key layout
   localparam int unsigned MEM_DEPTH      = 17;
   localparam int unsigned MEM_AW         = 5;
   localparam int unsigned DIGIT_W        = 4;
   localparam int unsigned ROWS           = 4;
   localparam int unsigned COLS           = 3;
   localparam logic [3:0]  KEY_STAR       = 4'h9;
   localparam logic [3:0]  KEY_ZERO       = 4'hA;
   localparam logic [3:0]  KEY_HASH       = 4'hB;
   localparam logic [3:0]  ZERO_PULSES    = 4'hA;
   localparam int unsigned TMR_W          = 12;

   typedef enum logic [2:0] {
      ST_IDLE, ST_PAUSE, ST_FETCH, ST_LOAD, ST_BREAK, ST_MAKE, ST_GAP
   } dial_state_e;
endpackage

// [hdl/digit_mem.sv]
// small digit store with registered read data
`timescale 1ns/10ps
module digit_mem #(
   parameter int unsigned DEPTH = dialer_pkg::MEM_DEPTH,
   parameter int unsigned AW    = dialer_pkg::MEM_AW,
   parameter int unsigned WIDTH = dialer_pkg::DIGIT_W
) (
   input  wire logic             i_core_clk,
   input  wire logic             i_wr_en,
   input  wire logic [AW-1:0]    i_wr_addr,
   input  wire logic [WIDTH-1:0] i_wr_data,
   input  wire logic [AW-1:0]    i_rd_addr,
   output logic      [WIDTH-1:0] o_rd_data
);
   import dialer_pkg::*;

   logic [WIDTH-1:0] mem_q [DEPTH];

   always_ff @(posedge i_core_clk) begin
      if (i_wr_en && (i_wr_addr < AW'(DEPTH))) begin
         mem_q[i_wr_addr] <= i_wr_data;
      end
   end

   always_ff @(posedge i_core_clk) begin
      o_rd_data <= (i_rd_addr < AW'(DEPTH)) ? mem_q[i_rd_addr] : '0;
   end
endmodule // digit_mem

// [hdl/pulse_dialer_with_redial.sv]
// pulse dialer with redial: keypad checking, digit store, line pulsing
`timescale 1ns/10ps
// Contract
// [R1] each key digit becomes rotary-style line pulses
// [R2] off-hook, store key only when exactly one down
// [R3] seventeen digits kept, first seventeen form redial
// [R4] first digit clears memory, pause, then pulse
// [R5] digits keyed while pulsing append, all sent; digits keyed after the seventeenth are dropped and never sent
// [R6] hash or star redials after long on-hook
// [R7] on-hook: time base halted, keys ignored
// [R8] select pins pick pulse rate and ratio
module pulse_dialer_with_redial #(
   parameter int unsigned TICK_CYCLES   = dialer_pkg::TICK_CYCLES,
   parameter int unsigned ONHOOK_CYCLES = dialer_pkg::ONHOOK_CYCLES
) (
   input  wire logic                       i_core_clk,
   input  wire logic                       i_rst_n,
   input  wire logic                       i_off_hook,
   input  wire logic [dialer_pkg::ROWS-1:0] i_row_n,
   input  wire logic [dialer_pkg::COLS-1:0] i_col_n,
   input  wire logic                       i_rate20_sel,
   input  wire logic                       i_ratio_sel,
   output logic                            o_line_break,
   output logic                            o_mute,
   output logic                            o_osc_run
);
   import dialer_pkg::*;

   // ==========================================================
   // time base, halted on-hook
   logic [31:0] div_q;
   logic        tick_q;
   logic        off_q;

   always_ff @(posedge i_core_clk) begin
      off_q <= i_rst_n ? i_off_hook : 1'b0;
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n || !off_q) begin
         div_q  <= '0; // [R7]
         tick_q <= 1'b0;
      end else if (div_q == TICK_CYCLES - 1) begin
         div_q  <= '0;
         tick_q <= 1'b1;
      end else begin
         div_q  <= div_q + 32'd1;
         tick_q <= 1'b0;
      end
   end

   // ==========================================================
   // keypad check
   logic [1:0] row_idx, col_idx;
   logic [2:0] row_cnt, col_cnt;
   logic       one_key;
   logic       any_key;

   always_comb begin
      row_cnt = '0;
      col_cnt = '0;
      row_idx = '0;
      col_idx = '0;
      for (int i = 0; i < ROWS; i++) begin
         if (!i_row_n[i]) begin
            row_cnt = row_cnt + 3'd1;
            row_idx = 2'(i);
         end
      end
      for (int j = 0; j < COLS; j++) begin
         if (!i_col_n[j]) begin
            col_cnt = col_cnt + 3'd1;
            col_idx = 2'(j);
         end
      end
      one_key = (row_cnt == 3'd1) && (col_cnt == 3'd1); // [R2]
      any_key = (row_cnt != 3'd0) || (col_cnt != 3'd0);
   end

   logic [3:0] code;
   assign code = 4'({row_idx, 2'b00} - {2'b00, row_idx} + {2'b00, col_idx});

   logic [3:0]  cand_q;
   logic [5:0]  deb_q;
   logic        held_q;
   logic        key_stb_q;
   logic [3:0]  key_q;

   // a key must stay single and steady, then be released before the next
   always_ff @(posedge i_core_clk) begin
      key_stb_q <= 1'b0;
      if (!i_rst_n || !off_q) begin
         deb_q  <= '0; // [R7]
         held_q <= 1'b0;
         cand_q <= '0;
         key_q  <= '0;
      end else if (!any_key) begin
         deb_q  <= '0;
         held_q <= 1'b0;
      end else if (!one_key || code != cand_q) begin
         deb_q  <= '0; // [R2]
         cand_q <= code;
      end else if (tick_q && !held_q) begin
         if (deb_q == 6'(DEBOUNCE_MS - 1)) begin
            held_q    <= 1'b1;
            key_stb_q <= 1'b1;
            key_q     <= cand_q;
         end else begin
            deb_q <= deb_q + 6'd1;
         end
      end
   end

   // ==========================================================
   // hook timer for redial permission
   logic [31:0] hook_q;
   logic        redial_ok_q;

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         hook_q <= '0;
      end else if (off_q) begin
         hook_q <= '0;
      end else if (hook_q != ONHOOK_CYCLES) begin
         hook_q <= hook_q + 32'd1;
      end
   end

   // ==========================================================
   // digit store and dial sequencer
   dial_state_e          st_q;
   logic [MEM_AW-1:0]    wr_cnt_q;
   logic [MEM_AW-1:0]    rd_ptr_q;
   logic                 call_q;
   logic [TMR_W-1:0]     tmr_q;
   logic [3:0]           pulses_q;
   logic [DIGIT_W-1:0]   rd_data;
   logic                 is_redial_key;
   logic                 wr_en;
   logic [MEM_AW-1:0]    wr_addr;
   logic [DIGIT_W-1:0]   wr_digit;
   logic [TMR_W-1:0]     brk_ms, mk_ms;

   assign is_redial_key = (key_q == KEY_STAR) || (key_q == KEY_HASH);
   assign wr_en   = key_stb_q && !is_redial_key && (!call_q || wr_cnt_q < MEM_AW'(MEM_DEPTH));
   assign wr_addr = call_q ? wr_cnt_q : '0; // [R4]
   assign wr_digit = (key_q == KEY_ZERO) ? ZERO_PULSES : key_q + 4'd1; // [R1]

   always_comb begin
      if (i_rate20_sel) begin
         brk_ms = i_ratio_sel ? TMR_W'(BRK20_B_MS) : TMR_W'(BRK20_A_MS); // [R8]
         mk_ms  = TMR_W'(PERIOD20_MS) - brk_ms;
      end else begin
         brk_ms = i_ratio_sel ? TMR_W'(BRK10_B_MS) : TMR_W'(BRK10_A_MS); // [R8]
         mk_ms  = TMR_W'(PERIOD10_MS) - brk_ms;
      end
   end

   digit_mem #(
      .DEPTH (MEM_DEPTH),
      .AW    (MEM_AW),
      .WIDTH (DIGIT_W)
   ) u_mem (
      .i_core_clk (i_core_clk),
      .i_wr_en    (wr_en),
      .i_wr_addr  (wr_addr),
      .i_wr_data  (wr_digit),
      .i_rd_addr  (rd_ptr_q),
      .o_rd_data  (rd_data)
   );

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         redial_ok_q <= 1'b0;
      end else if (!off_q) begin
         redial_ok_q <= (hook_q == ONHOOK_CYCLES); // [R6]
      end else if (key_stb_q) begin
         redial_ok_q <= 1'b0;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         wr_cnt_q <= '0;
      end else if (wr_en) begin
         wr_cnt_q <= wr_addr + MEM_AW'(1); // [R3]
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n || !off_q) begin
         st_q     <= ST_IDLE; // [R7]
         call_q   <= 1'b0;
         rd_ptr_q <= '0;
         tmr_q    <= '0;
         pulses_q <= '0;
      end else begin
         if (key_stb_q && !call_q) begin
            if (!is_redial_key) begin
               call_q   <= 1'b1; // [R4]
               rd_ptr_q <= '0;
               st_q     <= ST_PAUSE;
               tmr_q    <= TMR_W'(PREDIAL_MS);
            end else if (redial_ok_q && wr_cnt_q != '0) begin
               call_q   <= 1'b1; // [R6]
               rd_ptr_q <= '0;
               st_q     <= ST_PAUSE;
               tmr_q    <= TMR_W'(PREDIAL_MS);
            end
         end else begin
            case (st_q)
               ST_IDLE: begin
                  // leave on a tick so the first break of the digit is whole
                  if (tick_q && call_q && rd_ptr_q < wr_cnt_q) begin
                     st_q <= ST_FETCH; // [R5]
                  end
               end
               ST_PAUSE: begin
                  if (tick_q) begin
                     if (tmr_q <= TMR_W'(1)) begin
                        st_q <= ST_FETCH; // [R4]
                     end else begin
                        tmr_q <= tmr_q - TMR_W'(1);
                     end
                  end
               end
               ST_FETCH: begin
                  st_q <= ST_LOAD;
               end
               ST_LOAD: begin
                  pulses_q <= rd_data; // [R1]
                  rd_ptr_q <= rd_ptr_q + MEM_AW'(1);
                  tmr_q    <= brk_ms;
                  st_q     <= ST_BREAK;
               end
               ST_BREAK: begin
                  if (tick_q) begin
                     if (tmr_q <= TMR_W'(1)) begin
                        tmr_q <= mk_ms;
                        st_q  <= ST_MAKE;
                     end else begin
                        tmr_q <= tmr_q - TMR_W'(1);
                     end
                  end
               end
               ST_MAKE: begin
                  if (tick_q) begin
                     if (tmr_q > TMR_W'(1)) begin
                        tmr_q <= tmr_q - TMR_W'(1);
                     end else if (pulses_q > 4'd1) begin
                        pulses_q <= pulses_q - 4'd1; // [R1]
                        tmr_q    <= brk_ms;
                        st_q     <= ST_BREAK;
                     end else begin
                        pulses_q <= '0;
                        tmr_q    <= TMR_W'(INTERDIGIT_MS);
                        st_q     <= ST_GAP;
                     end
                  end
               end
               ST_GAP: begin
                  if (tick_q) begin
                     if (tmr_q > TMR_W'(1)) begin
                        tmr_q <= tmr_q - TMR_W'(1);
                     end else if (rd_ptr_q < wr_cnt_q) begin
                        st_q <= ST_FETCH; // [R5]
                     end else begin
                        st_q <= ST_IDLE;
                     end
                  end
               end
               default: begin
                  st_q <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // registered outputs
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_line_break <= 1'b0;
         o_mute       <= 1'b0;
         o_osc_run    <= 1'b0;
      end else begin
         // a hook drop clears the line together with the time base
         o_line_break <= (st_q == ST_BREAK) && off_q; // [R1]
         o_mute       <= (st_q != ST_IDLE) && off_q;
         o_osc_run    <= off_q; // [R7]
      end
   end
endmodule // pulse_dialer_with_redial

// [tb/dialer_chk.sv]
// port assertions for the pulse dialer
`timescale 1ns/10ps
module dialer_chk #(
   parameter int unsigned TICK_CYCLES = 4
) (
   input wire logic       i_core_clk,
   input wire logic       i_rst_n,
   input wire logic       i_off_hook,
   input wire logic [3:0] i_row_n,
   input wire logic [2:0] i_col_n,
   input wire logic       i_rate20_sel,
   input wire logic       i_ratio_sel,
   input wire logic       o_line_break,
   input wire logic       o_mute,
   input wire logic       o_osc_run
);
   // =====
   // helper counters: break high time, made time inside a call
   logic [15:0] hi_q;
   logic [15:0] lo_q;
   logic [15:0] brk_w;
   logic [15:0] mk_w;
   assign brk_w = 16'(TICK_CYCLES * (i_rate20_sel ? (i_ratio_sel ? 33 : 30)
                                                  : (i_ratio_sel ? 67 : 60)));
   assign mk_w = 16'(TICK_CYCLES * (i_rate20_sel ? 50 : 100)) - brk_w;
   always_ff @(posedge i_core_clk) begin
      hi_q <= (!i_rst_n || !o_line_break) ? 16'h0 : hi_q + 16'h1;
   end
   always_ff @(posedge i_core_clk) begin
      lo_q <= (!i_rst_n || o_line_break || !o_mute) ? 16'h0 : lo_q + 16'h1;
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   // =====
   // assertions
   a_osc_tracks_hook: assert property (
      $past(i_rst_n, 3) |-> o_osc_run == $past(i_off_hook, 2))
      else $error("osc run does not follow hook");
   a_break_in_mute: assert property (o_line_break |-> o_mute)
      else $error("line broken outside a call");
   a_onhook_idle: assert property (!i_off_hook [*6] |-> !o_mute && !o_line_break)
      else $error("sequencer active on hook");
   a_mute_needs_hook: assert property (
      $rose(o_mute) |-> $past(i_off_hook, 2) && $past(o_osc_run))
      else $error("call started without time base");
   a_break_length: assert property (
      $fell(o_line_break) && i_off_hook |-> hi_q == brk_w)
      else $error("break length wrong");
   a_make_or_pause: assert property (
      $rose(o_line_break) |-> (lo_q == mk_w) || (lo_q >= 16'(299 * TICK_CYCLES)))
      else $error("make time or pause wrong");
   a_pause_first: assert property ($rose(o_mute) |-> !o_line_break [*8])
      else $error("pulse without pause");
   a_gap_after_call: assert property (
      $fell(o_mute) && i_off_hook |-> lo_q >= 16'(799 * TICK_CYCLES))
      else $error("call ended without gap");
   a_osc_for_break: assert property (o_line_break |-> o_osc_run)
      else $error("pulse with time base stopped");
   c_pulse: cover property ($rose(o_line_break));
   c_call_end: cover property ($fell(o_mute) && i_off_hook);
   c_fast_call: cover property ($rose(o_mute) && i_rate20_sel);
endmodule // dialer_chk

// [tb/keypad_model.sv]
// keypad matrix model: no key, one key or two keys down
`timescale 1ns/10ps
module keypad_model (
   input  wire logic [3:0] i_key,
   input  wire logic       i_down,
   input  wire logic       i_dual,
   output logic      [3:0] o_row_n,
   output logic      [2:0] o_col_n
);
   logic [3:0] k2;
   always_comb begin
      k2 = (i_key + 4'h4) % 4'hC;
      // released lines sit at the pull-up level
      o_row_n = 4'hF;
      o_col_n = 3'h7;
      if (i_down) begin
         o_row_n[i_key / 3] = 1'b0;
         o_col_n[i_key % 3] = 1'b0;
      end
      if (i_down && i_dual) begin
         o_row_n[k2 / 3] = 1'b0;
         o_col_n[k2 % 3] = 1'b0;
      end
   end
endmodule // keypad_model

// [tb/pulse_dialer_with_redial_tb.sv]
// self-checking bench for the pulse dialer
`timescale 1ns/10ps
module pulse_dialer_with_redial_tb;
   import dialer_pkg::*;
   localparam int unsigned TK = 2;
   logic        i_core_clk;
   logic        i_rst_n = 1'b0;
   logic        i_off_hook = 1'b0;
   logic [3:0]  i_row_n;
   logic [2:0]  i_col_n;
   logic        i_rate20_sel = 1'b0;
   logic        i_ratio_sel = 1'b0;
   logic        o_line_break;
   logic        o_mute;
   logic        o_osc_run;
   logic [3:0]  key = 4'h0;
   logic        down = 1'b0;
   logic        dual = 1'b0;
   logic [15:0] cur = 16'h0;
   logic [15:0] brk_len = 16'h0;
   int          pulses = 0;
   int          err_total = 0;
   int          checks_done = 0;
   pulse_dialer_with_redial #(.TICK_CYCLES(TK), .ONHOOK_CYCLES(50))
      pulse_dialer_with_redial_inst (.i_core_clk, .i_rst_n, .i_off_hook, .i_row_n,
      .i_col_n, .i_rate20_sel, .i_ratio_sel, .o_line_break, .o_mute, .o_osc_run);
   keypad_model keypad_model_inst (.i_key(key), .i_down(down), .i_dual(dual),
      .o_row_n(i_row_n), .o_col_n(i_col_n));
   initial begin
      i_core_clk = 1'b0;
      forever #50 i_core_clk = ~i_core_clk;
   end
   // =====
   // line monitor: pulse count and last break length
   always @(posedge i_core_clk) begin
      cur <= (o_line_break === 1'b1) ? cur + 16'h1 : 16'h0;
      if (o_line_break === 1'b1) brk_len <= cur + 16'h1;
      if (o_line_break === 1'b1 && cur == 16'h0) pulses <= pulses + 1;
   end
   task automatic check(input string what, input logic [15:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s exp %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask
   // sel picks the line output (1) or the mute output (0); a timeout is a mismatch
   task automatic wait_on(input logic sel, input logic v, input int lim);
      int n;
      n = 0;
      while (((sel ? o_line_break : o_mute) !== v) && n < lim) begin
         cyc(1);
         n++;
      end
      check("wait_done", 16'(n < lim), 16'h1);
   endtask
   // a short on-hook spell ends the call but is too short for redial
   task automatic hang_up(input int n);
      i_off_hook <= 1'b0;
      cyc(n);
      i_off_hook <= 1'b1;
      cyc(5);
   endtask
   // a press outlasts the 20 tick check, then all keys are let go
   task automatic press(input logic [3:0] k, input logic two);
      key <= k;
      dual <= two;
      down <= 1'b1;
      cyc(25 * TK);
      down <= 1'b0;
      cyc(10 * TK);
   endtask
   task automatic finish_call(input int p0, input int np, input int bt);
      wait_on(1'b0, 1'b0, 40000);
      check("pulses", 16'(pulses - p0), 16'(np));
      check("break_len", brk_len, 16'(bt * TK));
   endtask
   // =====
   // scenarios
   task automatic t_digit;
      int p0;
      p0 = pulses;
      press(4'h2, 1'b0);
      check("mute_up", o_mute, 1'b1);
      check("line_in_pause", o_line_break, 1'b0);
      finish_call(p0, 3, 60);
   endtask
   task automatic t_dual;
      press(4'h4, 1'b1);
      cyc(10);
      check("mute_dual", o_mute, 1'b0);
   endtask
   // the call stays open until on-hook, so a new first digit needs a hang-up
   task automatic t_append;
      int p0;
      hang_up(10);
      i_rate20_sel <= 1'b1;
      i_ratio_sel <= 1'b1;
      p0 = pulses;
      press(KEY_ZERO, 1'b0);
      wait_on(1'b1, 1'b1, 2000);
      press(4'h1, 1'b0);
      finish_call(p0, 12, 33);
   endtask
   task automatic t_redial;
      int p0;
      i_off_hook <= 1'b0;
      press(4'h4, 1'b0);
      check("mute_onhook", o_mute, 1'b0);
      check("osc_onhook", o_osc_run, 1'b0);
      i_off_hook <= 1'b1;
      cyc(5);
      p0 = pulses;
      press(KEY_HASH, 1'b0);
      finish_call(p0, 12, 33);
   endtask
   task automatic t_short;
      hang_up(10);
      press(KEY_STAR, 1'b0);
      cyc(10);
      check("mute_short", o_mute, 1'b0);
   endtask
   // eighteen quick ones: the last must be dropped
   task automatic t_full;
      int p0;
      i_ratio_sel <= 1'b0;
      p0 = pulses;
      repeat (18) press(4'h0, 1'b0);
      finish_call(p0, 17, 30);
   endtask
   // slow rate with the long break
   task automatic t_slow;
      int p0;
      hang_up(10);
      i_rate20_sel <= 1'b0;
      i_ratio_sel <= 1'b1;
      p0 = pulses;
      press(4'h0, 1'b0);
      finish_call(p0, 1, 67);
   endtask
   task automatic wrap_up;
      if (err_total == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      cyc(5);
      i_rst_n <= 1'b1;
      i_off_hook <= 1'b1;
      cyc(10);
      check("osc_run", o_osc_run, 1'b1);
      t_digit();
      t_dual();
      t_append();
      t_redial();
      t_short();
      t_full();
      t_slow();
      wrap_up();
   end
   // the scenarios need about 46000 cycles
   initial begin
      cyc(60000);
      err_total++;
      wrap_up();
   end
endmodule // pulse_dialer_with_redial_tb
bind pulse_dialer_with_redial dialer_chk #(.TICK_CYCLES(TICK_CYCLES)) dialer_chk_inst (
   .i_core_clk, .i_rst_n, .i_off_hook, .i_row_n, .i_col_n, .i_rate20_sel,
   .i_ratio_sel, .o_line_break, .o_mute, .o_osc_run);
